// ===== logic/pmw_consts.svh
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH
// ****************************************
// Timing
// ****************************************
`define PMW_CLOCK_HZ 20000000
`define PMW_SLOW_HZ 32768
`define PMW_MS_PER_S 1000
`define PMW_DEGLITCH_MS 50
`define PMW_POWERUP_MS 600
`define PMW_LONG_S 8
`define PMW_LONG_EXT_S 15
`define PMW_PWRDOWN_MS 500
`define PMW_WAKE_TICKS 3'h5
`define PMW_TIMER_W 20
// ****************************************
// Register map (byte addresses)
// ****************************************
`define PMW_ADDR_W 8
`define PMW_OFF_CTRL 8'h00
`define PMW_OFF_STATUS 8'h04
`define PMW_OFF_IRQ 8'h08
`define PMW_OFF_CORE_A 8'h0C
`define PMW_OFF_CORE_B 8'h10
`define PMW_OFF_STRAP_A 8'h14
`define PMW_OFF_STRAP_B 8'h18
`define PMW_CTRL_RESET 8'h07
`define PMW_IRQ_BUTTON 0
`define PMW_ST_LEVEL 0
`define PMW_ST_CORE_EVT 1
`define PMW_ST_STATE 4
// ****************************************
// Voltage codes
// ****************************************
`define PMW_CORE_A_DEFAULT 6'h08
`define PMW_CORE_B_DEFAULT 6'h08
`define PMW_STRAP_A_PROG 6'h10
`define PMW_STRAP_B_PROG 6'h30
`define PMW_STRAP_A_R1 6'h12
`define PMW_STRAP_A_R2 6'h18
`define PMW_STRAP_A_R3 6'h1F
`define PMW_STRAP_A_R4 6'h3D
`define PMW_STRAP_B_R4 6'h01
`define PMW_STRAP_B_R5 6'h07
`define PMW_STRAP_B_R6 6'h0D
`define PMW_STRAP_B_R7 6'h14
`endif

// ===== logic/pmw_pkg.sv
package pmw_pkg;
  typedef enum logic [2:0] {
    PMW_OFF = 3'b000,
    PMW_WAKE = 3'b001,
    PMW_ACTIVE = 3'b010,
    PMW_DOWN = 3'b011,
    PMW_RECOVER = 3'b100
  } pmw_state_type;

  typedef struct packed {
    logic buttonIrqMask;
    logic longReset;
    logic coreResetEnable;
    logic pinTwoPushpullSel;
    logic memresetModeSel;
    logic pinThreeUserBit;
    logic pinTwoUserBit;
    logic pinOneUserBit;
  } pmw_ctrl_type;
endpackage

// ===== logic/pmw_pin_wake.sv
// The APB interface to the registers and the register addresses were decided locally.
`include "pmw_consts.svh"

// Behaviour
// - Open-drain pin one follows user bit
// - Memory mode with power good: copy pin one
// - Pin two low after reset, holds otherwise
// - Normal mode pin two follows user bit
// - Memory mode ignores pin two user bit
// - Open-drain pin three follows user bit
// - Pin three fall restores core voltage codes
// - Core rails re-slew, never power cycled
// - Strap range picks strap regulator defaults
// - Button deglitched over fifty milliseconds
// - Button low 600 ms starts power-up
// - Active button change sets maskable flag
// - Status shows present button level
// - Active button fall pulses wake five ticks
// - Long press enters recovery, then restarts
// - Held button repeats restart each interval
// - Charger falling edge starts power-up
// - Charger low wakes on supply valid
// - Charger high never causes power-up
// - Reading flags clears them, release output
// - Enable low leaves active, high wakes
module pmw_pin_wake import pmw_pkg::*; #(
  parameter int CLOCK_HZ = `PMW_CLOCK_HZ,
  parameter int SLOW_HZ = `PMW_SLOW_HZ,
  parameter int DEGLITCH_MS = `PMW_DEGLITCH_MS,
  parameter int POWERUP_MS = `PMW_POWERUP_MS,
  parameter int LONG_S = `PMW_LONG_S,
  parameter int LONG_EXT_S = `PMW_LONG_EXT_S,
  parameter int PWRDOWN_MS = `PMW_PWRDOWN_MS
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PMW_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic pinOneIn,
  output logic pinOneOut,
  output logic pinOneOe,
  output logic pinTwoOut,
  output logic pinTwoOe,
  input wire logic pinThreeIn,
  output logic pinThreeOut,
  output logic pinThreeOe,
  input wire logic seqPinOneLow,
  input wire logic seqPinThreeLow,
  input wire logic powerGood,
  input wire logic pushButton,
  input wire logic chargerDetect,
  input wire logic powerEnableIn,
  input wire logic supplyValid,
  input wire logic [2:0] strapResistor,
  output logic wakeOutN,
  output logic irqOutN,
  output logic railsOn,
  output logic [5:0] coreRegA,
  output logic [5:0] coreRegB,
  output logic [5:0] strapRegA,
  output logic [5:0] strapRegB
);
  // ****************************************
  // Derived counts
  // ****************************************
  function automatic int ticksFromMs(input int ms);
    return (ms * SLOW_HZ + `PMW_MS_PER_S - 1) / `PMW_MS_PER_S;
  endfunction

  localparam int TICK_DIV = CLOCK_HZ / SLOW_HZ;
  localparam int DEGLITCH_TICKS = ticksFromMs(DEGLITCH_MS);
  localparam int POWERUP_TICKS = ticksFromMs(POWERUP_MS);
  localparam int LONG_TICKS = ticksFromMs(LONG_S * `PMW_MS_PER_S);
  localparam int LONG_EXT_TICKS = ticksFromMs(LONG_EXT_S * `PMW_MS_PER_S);
  localparam int PWRDOWN_TICKS = ticksFromMs(PWRDOWN_MS);
  localparam logic [`PMW_TIMER_W-1:0] DEGLITCH_LAST = `PMW_TIMER_W'(DEGLITCH_TICKS - 1);
  localparam logic [`PMW_TIMER_W-1:0] POWERUP_CNT = `PMW_TIMER_W'(POWERUP_TICKS);
  localparam logic [`PMW_TIMER_W-1:0] LONG_CNT = `PMW_TIMER_W'(LONG_TICKS);
  localparam logic [`PMW_TIMER_W-1:0] LONG_EXT_CNT = `PMW_TIMER_W'(LONG_EXT_TICKS);
  localparam logic [`PMW_TIMER_W-1:0] PWRDOWN_LAST = `PMW_TIMER_W'(PWRDOWN_TICKS - 1);
  localparam logic [`PMW_TIMER_W-1:0] TIMER_MAX = '1;
  localparam logic [15:0] DIV_LAST = 16'(TICK_DIV - 1);

  function automatic logic [5:0] strapDecodeA(input logic [2:0] range);
    unique case (range)
      3'h1: return `PMW_STRAP_A_R1;
      3'h2: return `PMW_STRAP_A_R2;
      3'h3: return `PMW_STRAP_A_R3;
      3'h4: return `PMW_STRAP_A_R4;
      default: return `PMW_STRAP_A_PROG;
    endcase
  endfunction

  function automatic logic [5:0] strapDecodeB(input logic [2:0] range);
    unique case (range)
      3'h4: return `PMW_STRAP_B_R4;
      3'h5: return `PMW_STRAP_B_R5;
      3'h6: return `PMW_STRAP_B_R6;
      3'h7: return `PMW_STRAP_B_R7;
      default: return `PMW_STRAP_B_PROG;
    endcase
  endfunction

  pmw_ctrl_type ctrl;
  pmw_state_type state;
  logic [15:0] divCount;
  logic tick;
  logic [`PMW_TIMER_W-1:0] deglitchCount;
  logic [`PMW_TIMER_W-1:0] pressTicks;
  logic [`PMW_TIMER_W-1:0] stateTicks;
  logic pbStable;
  logic pbPrev;
  logic pbChange;
  logic pbFall;
  logic longPress;
  logic chargerPrev;
  logic supplyPrev;
  logic chargerFall;
  logic wakeReq;
  logic [2:0] wakeCount;
  logic irqFlag;
  logic next_irqFlag;
  logic memLevel;
  logic pinThreePrev;
  logic coreFall;
  logic coreEvent;
  logic strapDone;
  logic setupPhase;
  logic accept;
  logic readIrq;
  logic [31:0] readMux;
  logic mapped;

  // ****************************************
  // Slow tick
  // ****************************************
  // One divider feeds every timer so they stay phase aligned
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      divCount <= '0;
      tick <= 1'b0;
    end else if (divCount == DIV_LAST) begin
      divCount <= '0;
      tick <= 1'b1;
    end else begin
      divCount <= divCount + 16'h0001;
      tick <= 1'b0;
    end
  end

  // ****************************************
  // Button deglitch and press timer
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pbStable <= 1'b1;
      deglitchCount <= '0;
    end else if (tick) begin
      if (pushButton == pbStable) begin
        deglitchCount <= '0;
      end else if (deglitchCount == DEGLITCH_LAST) begin
        pbStable <= pushButton;
        deglitchCount <= '0;
      end else begin
        deglitchCount <= deglitchCount + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pbPrev <= 1'b1;
    end else begin
      pbPrev <= pbStable;
    end
  end

  assign pbChange = pbPrev != pbStable;
  assign pbFall = pbPrev && !pbStable;

  // Cleared on recovery entry so a held button restarts again later
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pressTicks <= '0;
    end else if (pbStable || (longPress && state != PMW_OFF && state != PMW_RECOVER)) begin
      pressTicks <= '0;
    end else if (tick && pressTicks != TIMER_MAX) begin
      pressTicks <= pressTicks + 1'b1;
    end
  end

  assign longPress = pressTicks >= (ctrl.longReset ? LONG_EXT_CNT : LONG_CNT);

  // ****************************************
  // Power state
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      chargerPrev <= 1'b1;
      supplyPrev <= 1'b0;
    end else begin
      chargerPrev <= chargerDetect;
      supplyPrev <= supplyValid;
    end
  end

  assign chargerFall = chargerPrev && !chargerDetect && supplyValid;
  assign wakeReq = pressTicks >= POWERUP_CNT
      || chargerFall
      || (!chargerDetect && supplyValid && !supplyPrev)
      || powerEnableIn;

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state <= PMW_OFF;
      stateTicks <= '0;
    end else begin
      unique case (state)
        PMW_OFF: begin
          if (wakeReq) begin
            state <= PMW_WAKE;
          end
        end
        PMW_WAKE, PMW_ACTIVE, PMW_DOWN: begin
          stateTicks <= '0;
          if (longPress) begin
            state <= PMW_RECOVER;
          end else if (state == PMW_WAKE && powerEnableIn) begin
            state <= PMW_ACTIVE;
          end else if (state == PMW_ACTIVE && !powerEnableIn) begin
            state <= PMW_DOWN;
          end else if (state == PMW_DOWN && tick) begin
            if (stateTicks == PWRDOWN_LAST) begin
              state <= PMW_OFF;
            end else begin
              stateTicks <= stateTicks + 1'b1;
            end
          end else if (state == PMW_DOWN) begin
            stateTicks <= stateTicks;
          end
        end
        PMW_RECOVER: begin
          if (tick) begin
            if (stateTicks == PWRDOWN_LAST) begin
              state <= PMW_WAKE;
              stateTicks <= '0;
            end else begin
              stateTicks <= stateTicks + 1'b1;
            end
          end
        end
        default: begin
          state <= PMW_OFF;
        end
      endcase
    end
  end

  // Backup rails are outside this block and stay on in recovery
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      railsOn <= 1'b0;
    end else begin
      railsOn <= state == PMW_WAKE || state == PMW_ACTIVE || state == PMW_DOWN;
    end
  end

  // ****************************************
  // Wake pulse
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wakeCount <= '0;
      wakeOutN <= 1'b1;
    end else if (pbFall && state == PMW_ACTIVE) begin
      wakeCount <= `PMW_WAKE_TICKS;
      wakeOutN <= 1'b0;
    end else if (tick && wakeCount != 3'h0) begin
      wakeCount <= wakeCount - 3'h1;
      wakeOutN <= wakeCount == 3'h1;
    end
  end

  // ****************************************
  // Interrupt flag
  // ****************************************
  // Set wins over a read clear that lands in the same cycle
  always_comb begin
    next_irqFlag = irqFlag;
    if (readIrq && prdata[`PMW_IRQ_BUTTON]) begin
      next_irqFlag = 1'b0;
    end
    if (pbChange && state == PMW_ACTIVE) begin
      next_irqFlag = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      irqFlag <= 1'b0;
      irqOutN <= 1'b1;
    end else begin
      irqFlag <= next_irqFlag;
      irqOutN <= !(next_irqFlag && !next_ctrl_mask());
    end
  end

  function automatic logic next_ctrl_mask();
    if (accept && pwrite && paddr == `PMW_OFF_CTRL) begin
      return pwdata[7];
    end
    return ctrl.buttonIrqMask;
  endfunction

  // ****************************************
  // Pins
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      memLevel <= 1'b0;
    end else if (ctrl.memresetModeSel && powerGood) begin
      memLevel <= pinOneIn;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pinOneOut <= 1'b0;
      pinOneOe <= 1'b0;
      pinTwoOut <= 1'b0;
      pinTwoOe <= 1'b0;
      pinThreeOut <= 1'b0;
      pinThreeOe <= 1'b0;
    end else begin
      pinOneOut <= 1'b0;
      pinOneOe <= !ctrl.memresetModeSel && (!ctrl.pinOneUserBit || seqPinOneLow);
      if (ctrl.memresetModeSel) begin
        pinTwoOut <= memLevel;
        pinTwoOe <= ctrl.pinTwoPushpullSel || !memLevel;
      end else begin
        pinTwoOut <= ctrl.pinTwoUserBit;
        pinTwoOe <= ctrl.pinTwoPushpullSel || !ctrl.pinTwoUserBit;
      end
      pinThreeOut <= 1'b0;
      pinThreeOe <= !ctrl.coreResetEnable && (!ctrl.pinThreeUserBit || seqPinThreeLow);
    end
  end

  // ****************************************
  // Core reset and strap
  // ****************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pinThreePrev <= 1'b1;
    end else begin
      pinThreePrev <= pinThreeIn;
    end
  end

  assign coreFall = ctrl.coreResetEnable && pinThreePrev && !pinThreeIn;

  // Only the code changes; the regulator slews to it while staying on
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      coreRegA <= `PMW_CORE_A_DEFAULT;
      coreRegB <= `PMW_CORE_B_DEFAULT;
      coreEvent <= 1'b0;
    end else if (coreFall) begin
      coreRegA <= `PMW_CORE_A_DEFAULT;
      coreRegB <= `PMW_CORE_B_DEFAULT;
      coreEvent <= 1'b1;
    end else if (accept && pwrite && paddr == `PMW_OFF_CORE_A) begin
      coreRegA <= pwdata[5:0];
    end else if (accept && pwrite && paddr == `PMW_OFF_CORE_B) begin
      coreRegB <= pwdata[5:0];
    end else if (accept && !pwrite && paddr == `PMW_OFF_STATUS) begin
      coreEvent <= 1'b0;
    end
  end

  // Strap pins are read once, just after reset release
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strapDone <= 1'b0;
      strapRegA <= `PMW_STRAP_A_PROG;
      strapRegB <= `PMW_STRAP_B_PROG;
    end else if (!strapDone) begin
      strapDone <= 1'b1;
      strapRegA <= strapDecodeA(strapResistor);
      strapRegB <= strapDecodeB(strapResistor);
    end else if (accept && pwrite && paddr == `PMW_OFF_STRAP_A) begin
      strapRegA <= pwdata[5:0];
    end else if (accept && pwrite && paddr == `PMW_OFF_STRAP_B) begin
      strapRegB <= pwdata[5:0];
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  assign setupPhase = psel && !penable;
  assign accept = psel && penable && pready;
  assign readIrq = accept && !pwrite && paddr == `PMW_OFF_IRQ;

  always_comb begin
    readMux = '0;
    mapped = 1'b1;
    unique case (paddr)
      `PMW_OFF_CTRL: readMux[7:0] = ctrl;
      `PMW_OFF_STATUS: begin
        readMux[`PMW_ST_LEVEL] = pbStable;
        readMux[`PMW_ST_CORE_EVT] = coreEvent;
        readMux[`PMW_ST_STATE +: 3] = state;
      end
      `PMW_OFF_IRQ: readMux[`PMW_IRQ_BUTTON] = irqFlag;
      `PMW_OFF_CORE_A: readMux[5:0] = coreRegA;
      `PMW_OFF_CORE_B: readMux[5:0] = coreRegB;
      `PMW_OFF_STRAP_A: readMux[5:0] = strapRegA;
      `PMW_OFF_STRAP_B: readMux[5:0] = strapRegB;
      default: mapped = 1'b0;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= setupPhase;
      pslverr <= setupPhase && !mapped;
      if (setupPhase) begin
        prdata <= pwrite ? 32'h0000_0000 : readMux;
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ctrl <= `PMW_CTRL_RESET;
    end else if (accept && pwrite && paddr == `PMW_OFF_CTRL) begin
      ctrl <= pwdata[7:0];
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  pin_one_od_a: assert property (@(posedge clock) disable iff (!reset_n)
    (!ctrl.memresetModeSel && !ctrl.pinOneUserBit) |=> (pinOneOe && !pinOneOut))
    else $error("pin one not driven low");
  mem_follow_a: assert property (@(posedge clock) disable iff (!reset_n)
    (ctrl.memresetModeSel && powerGood) ##1 ctrl.memresetModeSel
      |=> pinTwoOut == $past(pinOneIn, 2))
    else $error("pin two does not follow pin one");
  core_reset_a: assert property (@(posedge clock) disable iff (!reset_n)
    coreFall |=> (coreRegA == `PMW_CORE_A_DEFAULT && coreRegB == `PMW_CORE_B_DEFAULT))
    else $error("core codes not restored");
  wake_pulse_a: assert property (@(posedge clock) disable iff (!reset_n)
    (pbFall && state == PMW_ACTIVE) |=> !wakeOutN [*2])
    else $error("wake pulse missing");
  irq_set_a: assert property (@(posedge clock) disable iff (!reset_n)
    (pbChange && state == PMW_ACTIVE) |=> irqFlag)
    else $error("button change flag not set");
  irq_gate_a: assert property (@(posedge clock) disable iff (!reset_n)
    irqOutN == !(irqFlag && !ctrl.buttonIrqMask))
    else $error("interrupt output disagrees with flag and mask");
  long_press_a: assert property (@(posedge clock) disable iff (!reset_n)
    (longPress && (state == PMW_ACTIVE || state == PMW_WAKE)) |=> ##1 !railsOn)
    else $error("long press did not drop rails");
  charger_wake_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == PMW_OFF && chargerFall) |=> state == PMW_WAKE)
    else $error("charger edge did not wake");
  stay_active_a: assert property (@(posedge clock) disable iff (!reset_n)
    (state == PMW_ACTIVE && powerEnableIn && !longPress) |=> state == PMW_ACTIVE)
    else $error("left active with enable high");
endmodule

// ===== tb/pmw_partner.sv
// ****************************************
// Host, button and pull-ups on the pins
// ****************************************
module pmw_partner (
  input wire logic pinOneOe,
  input wire logic pinTwoOut,
  input wire logic pinTwoOe,
  input wire logic pinThreeOe,
  input wire logic hostOne,
  input wire logic hostThree,
  input wire logic pressed,
  output logic pinOneIn,
  output logic pinThreeIn,
  output logic pinTwoLevel,
  output logic pushButton
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups give 1 when nobody drives low, so a floating pin never reads as 0
  assign pinOneIn = pinOneOe ? 1'b0 : hostOne;
  assign pinThreeIn = pinThreeOe ? 1'b0 : hostThree;
  assign pinTwoLevel = pinTwoOe ? pinTwoOut : 1'b1;
  assign pushButton = !pressed;
endmodule

// ===== tb/pmw_pin_wake_tb.sv
`include "pmw_consts.svh"

module pmw_pin_wake_tb import pmw_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // Design and far side
  // ****************************************
  localparam int SHZ = 500;
  localparam int DIV = 2;
  localparam int DG = 10;
  localparam int PD = 20;
  logic clock, reset_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, v;
  logic pinOneIn, pinOneOut, pinOneOe, pinTwoOut, pinTwoOe, pinThreeIn, pinThreeOut;
  logic pinThreeOe, seqOne, seqThree, powerGood, pushButton, chargerDetect;
  logic powerEnableIn, supplyValid, wakeOutN, irqOutN, railsOn, err;
  logic hostOne, hostThree, pressed, pinTwoLevel;
  logic [2:0] strapResistor;
  logic [5:0] coreRegA, coreRegB, strapRegA, strapRegB;
  int mismatches, n_tests, cnt, len;

  pmw_pin_wake #(.CLOCK_HZ(1000), .SLOW_HZ(SHZ), .DEGLITCH_MS(DG), .POWERUP_MS(20),
    .LONG_S(1), .LONG_EXT_S(2), .PWRDOWN_MS(PD)) uut (
    .clock(clock), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pinOneIn(pinOneIn), .pinOneOut(pinOneOut), .pinOneOe(pinOneOe), .pinTwoOut(pinTwoOut),
    .pinTwoOe(pinTwoOe), .pinThreeIn(pinThreeIn), .pinThreeOut(pinThreeOut),
    .pinThreeOe(pinThreeOe), .seqPinOneLow(seqOne), .seqPinThreeLow(seqThree),
    .powerGood(powerGood), .pushButton(pushButton), .chargerDetect(chargerDetect),
    .powerEnableIn(powerEnableIn), .supplyValid(supplyValid), .strapResistor(strapResistor),
    .wakeOutN(wakeOutN), .irqOutN(irqOutN), .railsOn(railsOn), .coreRegA(coreRegA),
    .coreRegB(coreRegB), .strapRegA(strapRegA), .strapRegB(strapRegB));

  pmw_partner far (.pinOneOe(pinOneOe), .pinTwoOut(pinTwoOut), .pinTwoOe(pinTwoOe),
    .pinThreeOe(pinThreeOe), .hostOne(hostOne), .hostThree(hostThree), .pressed(pressed),
    .pinOneIn(pinOneIn), .pinThreeIn(pinThreeIn), .pinTwoLevel(pinTwoLevel),
    .pushButton(pushButton));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task close_out;
    $display("tests %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Holds the whole request until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // No cycle count assumed; only the watchdog ends a stalled wait
    while (pready !== 1'b1) begin
      @(posedge clock);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rds;
    apb(1'b0, `PMW_OFF_STATUS, 32'h0);
  endtask

  task wst(input logic [2:0] s, input int lim);
    int n;
    n = 0;
    rds();
    while (rd[6:4] !== s && n < lim) begin
      n++;
      rds();
    end
  endtask

  task wrail(input logic lv, input int lim);
    cnt = 0;
    while (railsOn !== lv && cnt < lim) begin
      @(posedge clock);
      cnt++;
    end
  endtask

  task rst(input logic [2:0] s);
    @(posedge clock);
    reset_n <= 1'b0;
    strapResistor <= s;
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    repeat (2) @(posedge clock);
  endtask

  function automatic logic [11:0] strap_exp(input logic [2:0] s);
    logic [5:0] a, b;
    a = `PMW_STRAP_A_PROG;
    b = `PMW_STRAP_B_PROG;
    case (s)
      3'h1: a = 6'h12;
      3'h2: a = 6'h18;
      3'h3: a = 6'h1F;
      3'h4: begin
        a = 6'h3D;
        b = 6'h01;
      end
      3'h5: b = 6'h07;
      3'h6: b = 6'h0D;
      3'h7: b = 6'h14;
      default: ;
    endcase
    return {a, b};
  endfunction
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    #2000000;
    mismatches++;
    close_out();
  end

  initial begin
    {reset_n, psel, penable, pwrite, paddr, pwdata, seqOne, seqThree} = '0;
    {powerGood, powerEnableIn, supplyValid, strapResistor, pressed} = '0;
    {chargerDetect, hostOne, hostThree} = 3'h7;
    mismatches = 0;
    n_tests = 0;
    void'($urandom(32'h755fe711));
    for (int i = 0; i < 8; i++) begin
      rst(i[2:0]);
      chk({strapRegA, strapRegB}, strap_exp(i[2:0]));
    end
    apb(1'b0, `PMW_OFF_CTRL, 32'h0);
    chk(rd, 32'h07);
    apb(1'b0, 8'hFC, 32'h0);
    chk({err, rd[30:0]}, 32'h80000000);
    $display("strap and reset test done");
    apb(1'b1, `PMW_OFF_CTRL, 32'h0F);
    repeat (3) @(posedge clock);
    chk({pinOneOe, pinTwoLevel}, 2'b00);
    powerGood <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      v = $urandom;
      hostOne <= v[8];
      seqOne <= v[9] & !v[3];
      seqThree <= v[10];
      apb(1'b1, `PMW_OFF_CTRL, {27'h0, v[4:0]});
      // Pin two lags pin one by two cycles, through memLevel and then the pin two register
      repeat (4) @(posedge clock);
      chk({pinOneOut, pinThreeOut}, 2'b00);
      chk(pinOneOe, !v[3] & (!v[0] | v[9]));
      chk(pinThreeOe, !v[2] | v[10]);
      chk(pinTwoLevel, v[3] ? v[8] : v[1]);
      chk(pinTwoOe, v[4] | !(v[3] ? v[8] : v[1]));
    end
    {seqOne, seqThree} <= 2'b00;
    hostOne <= 1'b1;
    apb(1'b1, `PMW_OFF_CTRL, 32'h08);
    repeat (3) @(posedge clock);
    powerGood <= 1'b0;
    repeat (2) @(posedge clock);
    hostOne <= 1'b0;
    repeat (3) @(posedge clock);
    chk(pinTwoLevel, 1'b1);
    $display("pin test done");
    apb(1'b1, `PMW_OFF_CORE_A, 32'h2A);
    apb(1'b1, `PMW_OFF_CORE_B, 32'h15);
    apb(1'b1, `PMW_OFF_CTRL, 32'h04);
    hostThree <= 1'b0;
    repeat (3) @(posedge clock);
    hostThree <= 1'b1;
    repeat (3) @(posedge clock);
    chk({coreRegA, coreRegB}, {6'h2A, 6'h15});
    apb(1'b1, `PMW_OFF_CTRL, 32'h24);
    hostThree <= 1'b0;
    repeat (3) @(posedge clock);
    chk({coreRegA, coreRegB}, {`PMW_CORE_A_DEFAULT, `PMW_CORE_B_DEFAULT});
    chk({strapRegA, strapRegB}, strap_exp(3'h7));
    apb(1'b0, `PMW_OFF_CTRL, 32'h0);
    chk(rd, 32'h24);
    hostThree <= 1'b1;
    $display("core reset test done");
    rst(3'h0);
    supplyValid <= 1'b1;
    repeat (40) @(posedge clock);
    rds();
    chk(rd[6:4], PMW_OFF);
    chargerDetect <= 1'b0;
    wst(PMW_WAKE, 10);
    chk(rd[6:4], PMW_WAKE);
    supplyValid <= 1'b0;
    rst(3'h0);
    supplyValid <= 1'b1;
    wst(PMW_WAKE, 10);
    chk(rd[6:4], PMW_WAKE);
    chargerDetect <= 1'b1;
    rst(3'h0);
    $display("charger test done");
    pressed <= 1'b1;
    repeat (4) @(posedge clock);
    pressed <= 1'b0;
    repeat (30) @(posedge clock);
    rds();
    chk(rd[6:4], PMW_OFF);
    chk(rd[0], 1'b1);
    pressed <= 1'b1;
    repeat (20) @(posedge clock);
    rds();
    chk(rd[6:4], PMW_OFF);
    wst(PMW_WAKE, 10);
    chk(rd[6:4], PMW_WAKE);
    chk(rd[0], 1'b0);
    pressed <= 1'b0;
    powerEnableIn <= 1'b1;
    wst(PMW_ACTIVE, 10);
    chk(rd[6:4], PMW_ACTIVE);
    repeat (30) @(posedge clock);
    apb(1'b0, `PMW_OFF_IRQ, 32'h0);
    pressed <= 1'b1;
    cnt = 0;
    while (wakeOutN !== 1'b0 && cnt < 40) begin
      @(posedge clock);
      cnt++;
    end
    len = 0;
    while (wakeOutN === 1'b0 && len < 40) begin
      @(posedge clock);
      len++;
    end
    chk(len inside {[4 * DIV:5 * DIV]}, 1'b1);
    chk(irqOutN, 1'b0);
    apb(1'b0, `PMW_OFF_IRQ, 32'h0);
    chk(rd[0], 1'b1);
    @(posedge clock);
    chk(irqOutN, 1'b1);
    pressed <= 1'b0;
    repeat (20) @(posedge clock);
    chk({irqOutN, wakeOutN}, 2'b01);
    apb(1'b0, `PMW_OFF_IRQ, 32'h0);
    chk(rd[0], 1'b1);
    apb(1'b1, `PMW_OFF_CTRL, 32'h87);
    pressed <= 1'b1;
    repeat (20) @(posedge clock);
    chk(irqOutN, 1'b1);
    apb(1'b0, `PMW_OFF_IRQ, 32'h0);
    chk(rd[0], 1'b1);
    pressed <= 1'b0;
    repeat (20) @(posedge clock);
    $display("button test done");
    for (int lr = 0; lr < 2; lr++) begin
      // Long press length in clocks, from the chosen interval
      len = (lr + 1) * SHZ * DIV;
      apb(1'b1, `PMW_OFF_CTRL, lr ? 32'h47 : 32'h07);
      pressed <= 1'b1;
      wrail(1'b0, len + 100);
      chk(cnt inside {[len:len + 2 * DG + 4]}, 1'b1);
      wrail(1'b1, 100);
      chk(cnt inside {[PD * DIV / 2 - 6:PD * DIV / 2 + 4]}, 1'b1);
      wrail(1'b0, len + 100);
      chk(cnt inside {[len - 30:len + 4]}, 1'b1);
      wrail(1'b1, 100);
      pressed <= 1'b0;
      // Release must pass the deglitch, or the next press inherits old ticks
      repeat (2 * DG) @(posedge clock);
      wst(PMW_ACTIVE, 20);
      chk(rd[6:4], PMW_ACTIVE);
    end
    $display("long press test done");
    powerEnableIn <= 1'b0;
    repeat (2) @(posedge clock);
    rds();
    chk(rd[6:4], PMW_DOWN);
    wst(PMW_OFF, 20);
    chk({rd[6:4], railsOn}, {PMW_OFF, 1'b0});
    $display("enable test done");
    close_out();
  end
endmodule
